// ===== rtl/rtcsl_pkg.sv
package rtcsl_pkg;
   // ------------------------------------------------------------
   // Slave address and byte framing
   // ------------------------------------------------------------
   localparam logic [3:0] SLV_GROUP1 = 4'hA;
   localparam logic [1:0] SLV_GROUP2_HI = 2'h0;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int PTR_RESET = 0;
   localparam int FIFO_DEPTH = 4;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      D_IDLE, D_DEV, D_WADDR, D_WDATA, D_ACK, D_TX, D_MACK, D_IGNORE
   } rtcsl_dstate_t;
   typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_WAIT} rtcsl_hstate_t;
   typedef enum logic [2:0] {P_DEVW, P_WADDR, P_WDATA, P_DEVR, P_RDATA} rtcsl_phase_t;
   typedef enum logic [1:0] {OP_WRITE, OP_READ_ADDR, OP_READ_CUR} rtcsl_op_t;
endpackage : rtcsl_pkg

// ===== rtl/rtcsl_link_if.sv
interface rtcsl_link_if;
   logic scl;
   logic sda;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;

   // Open-drain wired AND with pull-up
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface : rtcsl_link_if

// ===== rtl/rtcsl_dev.sv

module rtcsl_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [IW-1:0] wr_idx;
   logic [IW-1:0] rd_idx;
   logic [IW:0] level;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [IW-1:0] wr_nxt = (wr_idx == IW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
   wire [IW-1:0] rd_nxt = (rd_idx == IW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
   wire [IW:0] next_level = level + (IW + 1)'(push) - (IW + 1)'(pop);
   wire [IW-1:0] next_rd_idx = pop ? rd_nxt : rd_idx;
   // Entry written this cycle is not yet in storage
   wire bypass = push && (next_rd_idx == wr_idx);

   assign in_ready = (level != (IW + 1)'(DEPTH));

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wr_idx <= '0;
         rd_idx <= '0;
         level <= '0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_idx <= wr_nxt;
         end
         if (pop) begin
            rd_idx <= rd_nxt;
         end
         level <= next_level;
         out_valid <= (next_level != '0);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_idx] <= in_data;
      end
      out_data <= bypass ? in_data : mem[next_rd_idx];
   end
endmodule : rtcsl_fifo

module rtcsl_dev
   import rtcsl_pkg::*;
#(
   parameter int PTR_W = 8,
   parameter int WQ_DEPTH = FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rstn,
   rtcsl_link_if.dev link,
   input wire logic iface_reset_n,
   input wire logic address_select_input,
   output logic [PTR_W-1:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [PTR_W-1:0] wr_addr,
   output logic [7:0] wr_data,
   output logic busy
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] scl_s;
   logic [1:0] sda_s;
   logic [1:0] rst_s;
   logic [1:0] sel_s;
   logic scl_d;
   logic sda_d;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         rst_s <= 2'h0;
         sel_s <= 2'h0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], link.scl};
         sda_s <= {sda_s[0], link.sda};
         rst_s <= {rst_s[0], iface_reset_n};
         sel_s <= {sel_s[0], address_select_input};
         scl_d <= scl_s[1];
         sda_d <= sda_s[1];
      end
   end

   wire scl_rise = scl_s[1] && !scl_d;
   wire scl_fall = !scl_s[1] && scl_d;
   wire start_det = scl_s[1] && scl_d && sda_d && !sda_s[1];
   wire stop_det = scl_s[1] && scl_d && !sda_d && sda_s[1];

   // ------------------------------------------------------------
   // Link state
   // ------------------------------------------------------------
   rtcsl_dstate_t state;
   rtcsl_dstate_t ack_next;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic oe;
   logic more;
   logic [PTR_W-1:0] ptr;
   logic q_ready;

   wire byte_done = (cnt == BITS_PER_BYTE);
   wire addr_match = (sh[7:1] == {SLV_GROUP1, SLV_GROUP2_HI, sel_s[1]});
   wire q_push = (state == D_WDATA) && scl_fall && byte_done && rst_s[1]
      && !start_det && !stop_det;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state <= D_IDLE;
         ack_next <= D_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         oe <= 1'b0;
         more <= 1'b0;
         ptr <= PTR_W'(PTR_RESET);
         busy <= 1'b0;
      end else if (!rst_s[1]) begin
         state <= D_IDLE;
         oe <= 1'b0;
         cnt <= 4'h0;
         busy <= 1'b0;
      end else begin
         busy <= (state != D_IDLE);
         if (stop_det) begin
            state <= D_IDLE;
            oe <= 1'b0;
            cnt <= 4'h0;
         end else if (start_det) begin
            state <= D_DEV;
            oe <= 1'b0;
            cnt <= 4'h0;
         end else begin
            unique case (state)
               D_DEV, D_WADDR, D_WDATA: begin
                  if (scl_rise && !byte_done) begin
                     sh <= {sh[6:0], sda_s[1]};
                     cnt <= cnt + 4'h1;
                  end else if (scl_fall && byte_done) begin
                     cnt <= 4'h0;
                     if (state == D_DEV) begin
                        if (addr_match) begin
                           oe <= 1'b1;
                           state <= D_ACK;
                           ack_next <= (sh[0] == RW_READ) ? D_TX : D_WADDR;
                        end else begin
                           state <= D_IGNORE;
                        end
                     end else if (state == D_WADDR) begin
                        ptr <= PTR_W'(sh);
                        oe <= 1'b1;
                        state <= D_ACK;
                        ack_next <= D_WDATA;
                     end else if (q_ready) begin
                        ptr <= ptr + 1'b1;
                        oe <= 1'b1;
                        state <= D_ACK;
                        ack_next <= D_WDATA;
                     end else begin
                        state <= D_IGNORE;
                     end
                  end
               end
               D_ACK: begin
                  if (scl_fall) begin
                     state <= ack_next;
                     cnt <= 4'h0;
                     sh <= rd_data;
                     oe <= (ack_next == D_TX) ? !rd_data[7] : 1'b0;
                  end
               end
               D_TX: begin
                  if (scl_fall) begin
                     if (cnt == BIT_LAST) begin
                        oe <= 1'b0;
                        state <= D_MACK;
                     end else begin
                        sh <= {sh[6:0], 1'b0};
                        oe <= !sh[6];
                        cnt <= cnt + 4'h1;
                     end
                  end
               end
               D_MACK: begin
                  if (scl_rise) begin
                     ptr <= ptr + 1'b1;
                     more <= !sda_s[1];
                  end else if (scl_fall) begin
                     if (more) begin
                        sh <= rd_data;
                        oe <= !rd_data[7];
                        cnt <= 4'h0;
                        state <= D_TX;
                     end else begin
                        state <= D_IGNORE;
                     end
                  end
               end
               D_IDLE, D_IGNORE: begin
               end
            endcase
         end
      end
   end

   assign rd_addr = ptr;
   assign link.dev_sda_oe = oe;
   assign link.dev_sda_o = 1'b0;

   // ------------------------------------------------------------
   // Write queue towards the register store
   // ------------------------------------------------------------
   rtcsl_fifo #(
      .WIDTH(PTR_W + 8),
      .DEPTH(WQ_DEPTH)
   ) u_wq (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(q_push),
      .in_ready(q_ready),
      .in_data({ptr, sh}),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data({wr_addr, wr_data})
   );
endmodule : rtcsl_dev

// ===== rtl/rtcsl_host.sv
module rtcsl_host
   import rtcsl_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rstn,
   rtcsl_link_if.host link,
   input wire logic target_select,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire rtcsl_op_t cmd_op,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_count,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic done,
   output logic nack
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   rtcsl_hstate_t state;
   rtcsl_phase_t phase;
   rtcsl_op_t op;
   logic [1:0] sda_s;
   logic [15:0] div;
   logic [1:0] q;
   logic [3:0] bit_i;
   logic [8:0] sh;
   logic [8:0] rx;
   logic [7:0] addr;
   logic [7:0] count;
   logic scl;
   logic sda_oe;

   wire tick = (div == 16'(QUARTER - 1));
   wire cmd_take = cmd_valid && cmd_ready;
   wire wr_take = wr_valid && wr_ready;
   wire got_nack = rx[0];
   wire last = (count == 8'h01);
   wire [7:0] dev_w = {SLV_GROUP1, SLV_GROUP2_HI, target_select, RW_WRITE};
   wire [7:0] dev_r = {SLV_GROUP1, SLV_GROUP2_HI, target_select, RW_READ};
   wire slot_end = tick && (q == 2'h3);

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sda_s <= 2'h3;
      end else begin
         sda_s <= {sda_s[0], link.sda};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state <= H_IDLE;
         phase <= P_DEVW;
         op <= OP_WRITE;
         div <= 16'h0000;
         q <= 2'h0;
         bit_i <= 4'h0;
         sh <= 9'h1FF;
         rx <= 9'h000;
         addr <= 8'h00;
         count <= 8'h00;
         scl <= 1'b1;
         sda_oe <= 1'b0;
         cmd_ready <= 1'b0;
         wr_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         done <= 1'b0;
         nack <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         done <= 1'b0;
         cmd_ready <= (state == H_IDLE) && !cmd_take;
         wr_ready <= (state == H_WAIT) && !wr_take;
         div <= (tick || state == H_IDLE || state == H_WAIT) ? 16'h0000 : div + 16'h0001;
         if (cmd_take) begin
            op <= cmd_op;
            addr <= cmd_addr;
            count <= cmd_count;
            nack <= 1'b0;
            phase <= (cmd_op == OP_READ_CUR) ? P_DEVR : P_DEVW;
            state <= H_START;
            q <= 2'h0;
         end else if (wr_take) begin
            sh <= {wr_data, 1'b1};
            sda_oe <= !wr_data[7];
            bit_i <= 4'h0;
            q <= 2'h0;
            state <= H_BIT;
         end else if (tick && state != H_IDLE && state != H_WAIT) begin
            q <= q + 2'h1;
            if (q == 2'h0) begin
               scl <= 1'b1;
            end else if (q == 2'h1) begin
               if (state == H_START) begin
                  sda_oe <= 1'b1;
               end else if (state == H_STOP) begin
                  sda_oe <= 1'b0;
               end else begin
                  rx <= {rx[7:0], sda_s[1]};
               end
            end else if (q == 2'h2) begin
               scl <= (state == H_STOP);
            end else if (state == H_STOP) begin
               state <= H_IDLE;
               done <= 1'b1;
            end else if (state == H_START) begin
               sh <= (phase == P_DEVR) ? {dev_r, 1'b1} : {dev_w, 1'b1};
               sda_oe <= 1'b0; // Both address bytes begin with a one bit
               bit_i <= 4'h0;
               state <= H_BIT;
            end else if (bit_i != BITS_PER_BYTE) begin
               bit_i <= bit_i + 4'h1;
               sda_oe <= !sh[7];
               sh <= {sh[7:0], 1'b1};
            end else begin
               bit_i <= 4'h0;
               unique case (phase)
                  P_DEVW, P_DEVR, P_WADDR: begin
                     if (got_nack) begin
                        nack <= 1'b1;
                        sda_oe <= 1'b1;
                        state <= H_STOP;
                     end else if (phase == P_DEVW) begin
                        phase <= P_WADDR;
                        sh <= {addr, 1'b1};
                        sda_oe <= !addr[7];
                     end else if (phase == P_DEVR) begin
                        phase <= P_RDATA;
                        sh <= {8'hFF, last};
                        sda_oe <= 1'b0;
                     end else if (op == OP_WRITE) begin
                        phase <= P_WDATA;
                        sda_oe <= 1'b0;
                        state <= H_WAIT;
                     end else begin
                        phase <= P_DEVR;
                        sda_oe <= 1'b0;
                        state <= H_START;
                     end
                  end
                  P_WDATA: begin
                     count <= count - 8'h01;
                     nack <= got_nack;
                     sda_oe <= got_nack || last;
                     state <= (got_nack || last) ? H_STOP : H_WAIT;
                  end
                  P_RDATA: begin
                     rd_valid <= 1'b1;
                     rd_data <= rx[8:1];
                     count <= count - 8'h01;
                     if (last) begin
                        sda_oe <= 1'b1;
                        state <= H_STOP;
                     end else begin
                        sh <= {8'hFF, (count == 8'h02)};
                        sda_oe <= 1'b0;
                     end
                  end
               endcase
            end
         end
      end
   end

   assign link.scl = scl;
   assign link.host_sda_oe = sda_oe;
   assign link.host_sda_o = 1'b0;
endmodule : rtcsl_host

// ===== dv/rtcsl_monitor.sv
module rtcsl_monitor
   import rtcsl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic iface_reset_n,
   input wire logic address_select_input
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // Frame tracking
   // ------------------------------------------------------------
   logic scl_q, sda_q, rw;
   logic [3:0] bcnt, nbyte;
   logic [7:0] sh;
   wire logic rise = scl && !scl_q;
   wire logic fall = !scl && scl_q;
   wire logic start = scl && scl_q && sda_q && !sda;
   wire logic stop = scl && scl_q && !sda_q && sda;
   wire logic ack_clk = rise && bcnt == 4'h8;
   wire logic addr_hit = sh[7:1] == {SLV_GROUP1, SLV_GROUP2_HI, address_select_input};
   always_ff @(posedge ref_clk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (!rstn || start) begin
         bcnt <= 4'h0;
         nbyte <= 4'h0;
      end else if (rise) begin
         bcnt <= (bcnt == 4'h8) ? 4'h0 : bcnt + 4'h1;
         nbyte <= (bcnt == 4'h8) ? nbyte + 4'h1 : nbyte;
      end
      if (rise && bcnt < 4'h8)
         sh <= {sh[6:0], sda};
      if (rise && bcnt == 4'h7 && nbyte == 4'h0)
         rw <= sda;
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_addr_ack;
      ack_clk && nbyte == 4'h0 && addr_hit && iface_reset_n;
   endsequence
   sequence s_rx_ack_end;
      fall && bcnt == 4'h0 && nbyte != 4'h0 && !rw;
   endsequence
   property p_addr_ack;
      s_addr_ack |-> dev_sda_oe;
   endproperty
   a_addr_ack:
      assert property (p_addr_ack) else $error("own address not acknowledged");
   property p_addr_ignore;
      ack_clk && nbyte == 4'h0 && !addr_hit |-> !dev_sda_oe;
   endproperty
   a_addr_ignore:
      assert property (p_addr_ignore) else $error("foreign address acknowledged");
   property p_rx_bits_free;
      rise && bcnt != 4'h8 && (nbyte == 4'h0 || !rw) |-> !dev_sda_oe;
   endproperty
   a_rx_bits_free:
      assert property (p_rx_bits_free) else $error("data line held while receiving");
   property p_tx_release;
      ack_clk && nbyte != 4'h0 && rw |-> !dev_sda_oe;
   endproperty
   a_tx_release:
      assert property (p_tx_release) else $error("line held in master ack clock");
   property p_rx_release;
      s_rx_ack_end |-> ##[1:6] !dev_sda_oe;
   endproperty
   a_rx_release:
      assert property (p_rx_release) else $error("ack not released");
   property p_stop_quiet;
      stop |=> !dev_sda_oe [*8];
   endproperty
   a_stop_quiet:
      assert property (p_stop_quiet) else $error("line driven after stop");
   property p_iface_rst;
      !iface_reset_n [*6] |-> !dev_sda_oe;
   endproperty
   a_iface_rst:
      assert property (p_iface_rst) else $error("line driven in interface reset");
   property p_edge_scl_low;
      $changed(dev_sda_oe) |-> !scl && !dev_sda_o;
   endproperty
   a_edge_scl_low:
      assert property (p_edge_scl_low) else $error("data changed with clock high");
endmodule : rtcsl_monitor

// ===== dv/test_rtc_two_wire_slave_access.sv
module test_rtc_two_wire_slave_access
   import rtcsl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIM = 4000;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic iface_reset_n = 1'b1;
   logic strap = 1'b0;
   logic target = 1'b0;
   logic cmd_valid = 1'b0;
   rtcsl_op_t cmd_op = OP_WRITE;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_count = 8'h01;
   logic dev_wr_ready = 1'b1;
   logic [7:0] mem [256];
   logic [7:0] wq [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
   logic [7:0] rq [$];
   logic [2:0] widx = 3'h0;
   logic busy_seen = 1'b0;
   int fail_count = 0;
   int n_tests = 0;
   wire logic [7:0] rd_addr, rd_data, wr_addr, wr_data, h_rd_data;
   wire logic wr_valid, cmd_ready, h_wr_ready, rd_valid, done, nack, busy;
   // ------------------------------------------------------------
   // Store model and both ends
   // ------------------------------------------------------------
   always #10 ref_clk = ~ref_clk;
   assign rd_data = mem[rd_addr];
   always @(posedge ref_clk) begin
      if (!rstn) begin
         for (int i = 0; i < 256; i++) mem[i] <= pre(8'(i));
      end else if (wr_valid && dev_wr_ready) begin
         mem[wr_addr] <= wr_data;
      end
      if (cmd_valid) begin
         widx <= 3'h0;
         rq.delete();
         busy_seen <= 1'b0;
      end else begin
         if (h_wr_ready) widx <= widx + 3'h1;
         if (rd_valid) rq.push_back(h_rd_data);
         if (busy) busy_seen <= 1'b1;
      end
   end
   rtcsl_link_if rtcsl_link_if_i ();
   rtcsl_dev rtcsl_dev_i (.ref_clk(ref_clk), .rstn(rstn), .link(rtcsl_link_if_i),
      .iface_reset_n(iface_reset_n), .address_select_input(strap), .rd_addr(rd_addr),
      .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(dev_wr_ready), .wr_addr(wr_addr),
      .wr_data(wr_data), .busy(busy));
   rtcsl_host #(.QUARTER(5)) rtcsl_host_i (.ref_clk(ref_clk), .rstn(rstn),
      .link(rtcsl_link_if_i), .target_select(target), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
      .wr_valid(1'b1), .wr_ready(h_wr_ready), .wr_data(wq[widx]), .rd_valid(rd_valid),
      .rd_data(h_rd_data), .done(done), .nack(nack));
   rtcsl_monitor rtcsl_monitor_i (.ref_clk(ref_clk), .rstn(rstn),
      .scl(rtcsl_link_if_i.scl), .sda(rtcsl_link_if_i.sda),
      .dev_sda_o(rtcsl_link_if_i.dev_sda_o), .dev_sda_oe(rtcsl_link_if_i.dev_sda_oe),
      .iface_reset_n(iface_reset_n), .address_select_input(strap));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [7:0] pre(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction : pre
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_done(input logic is_ready);
      int k;
      k = 0;
      while ((is_ready ? !cmd_ready : !done) && k < LIM) begin
         @(posedge ref_clk);
         k++;
      end
      if (k == LIM) begin
         fail_count++;
         end_of_test();
      end
   endtask : wait_done
   task automatic run(input rtcsl_op_t op, input logic [7:0] addr, input logic [7:0] cnt);
      wait_done(1'b1);
      cmd_op <= op;
      cmd_addr <= addr;
      cmd_count <= cnt;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      @(posedge ref_clk);
      wait_done(1'b0);
      repeat (8) @(posedge ref_clk);
   endtask : run
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      run(OP_READ_CUR, 8'h00, 8'h02);
      check(rq[0], pre(8'h00));
      check(rq[1], pre(8'h01));
      check({7'h0, busy_seen}, 8'h01);
      check({7'h0, busy}, 8'h00);
      run(OP_WRITE, 8'h10, 8'h03);
      check({7'h0, nack}, 8'h00);
      for (int i = 0; i < 3; i++) check(mem[8'h10 + i], wq[i]);
      check(rd_addr, 8'h13);
      run(OP_READ_ADDR, 8'h0F, 8'h04);
      check(rq[0], pre(8'h0F));
      for (int i = 1; i < 4; i++) check(rq[i], wq[i - 1]);
      check(rd_addr, 8'h13);
      run(OP_READ_CUR, 8'h00, 8'h01);
      check(rq[0], pre(8'h13));
      target <= 1'b1;
      run(OP_WRITE, 8'h30, 8'h01);
      check({7'h0, nack}, 8'h01);
      check(mem[8'h30], pre(8'h30));
      strap <= 1'b1;
      repeat (4) @(posedge ref_clk);
      run(OP_WRITE, 8'h30, 8'h01);
      check(mem[8'h30], wq[0]);
      strap <= 1'b0;
      target <= 1'b0;
      dev_wr_ready <= 1'b0;
      repeat (4) @(posedge ref_clk);
      run(OP_WRITE, 8'h40, 8'h06);
      check({7'h0, nack}, 8'h01);
      check(rd_addr, 8'h44);
      dev_wr_ready <= 1'b1;
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) check(mem[8'h40 + i], wq[i]);
      check(mem[8'h44], pre(8'h44));
      iface_reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      run(OP_READ_CUR, 8'h00, 8'h01);
      check({7'h0, nack}, 8'h01);
      check({7'h0, busy_seen}, 8'h00);
      iface_reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      run(OP_READ_CUR, 8'h00, 8'h01);
      check(rq[0], pre(8'h44));
      end_of_test();
   end
endmodule : test_rtc_two_wire_slave_access
